/* File: design/fws_pkg.sv */
/*
  Constants for the flash status host: register map of the controller,
  status byte layout of the flash, pin timing as cycle counts.
  Assumes a single 100 MHz system clock.
*/
package fws_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int CNT_W         = 16;
  localparam int REG_AW        = 4;
  localparam int REG_DW        = 32;
  localparam int DQ_W          = 8;
  localparam int SYNC_LAT      = 3;  // Pin synchroniser depth

  // Least time in ns to whole cycles, rounded up, at least one
  function automatic int cyc_min(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_min

  // Pin timing in ns, as printed
  localparam int RESET_PULSE_MIN_NS        = 500;
  localparam int RESET_TO_STANDBY_TIME_NS  = 20000;
  localparam int RESET_HIGH_BEFORE_READ_NS = 50;
  localparam int READY_AFTER_ALGO_NS       = 20000;
  localparam int ADDRESS_ACCESS_TIME_NS    = 90;
  localparam int OE_HIGH_POLL_NS           = 20;
  localparam int WRITE_PULSE_NS            = 35;
  localparam int WRITE_PULSE_HIGH_NS       = 30;

  // Same times as cycle counts
  localparam logic [CNT_W-1:0] RP_CYC =
    CNT_W'(cyc_min(RESET_PULSE_MIN_NS));
  localparam logic [CNT_W-1:0] RPD_CYC =
    CNT_W'(cyc_min(RESET_TO_STANDBY_TIME_NS));
  localparam logic [CNT_W-1:0] RH_CYC =
    CNT_W'(cyc_min(RESET_HIGH_BEFORE_READ_NS));
  localparam logic [CNT_W-1:0] READY_CYC =
    CNT_W'(cyc_min(READY_AFTER_ALGO_NS));
  // Access time, one edge of margin, three sync stages, the filter flop
  localparam logic [CNT_W-1:0] ACC_CYC =
    CNT_W'(cyc_min(ADDRESS_ACCESS_TIME_NS) + SYNC_LAT + 2);
  localparam logic [CNT_W-1:0] OEPH_CYC =
    CNT_W'(cyc_min(OE_HIGH_POLL_NS));
  localparam logic [CNT_W-1:0] WP_CYC =
    CNT_W'(cyc_min(WRITE_PULSE_NS));
  localparam logic [CNT_W-1:0] WPH_CYC =
    CNT_W'(cyc_min(WRITE_PULSE_HIGH_NS));

  // Controller registers
  localparam logic [REG_AW-1:0] REG_CTRL      = 4'h0;
  localparam logic [REG_AW-1:0] REG_POLL_ADDR = 4'h1;
  localparam logic [REG_AW-1:0] REG_STATUS    = 4'h2;

  // Command bits of the control register
  localparam int CTRL_POLL        = 0;
  localparam int CTRL_RESET       = 1;
  localparam int CTRL_STANDBY     = 2;
  localparam int CTRL_ABORT_CLEAR = 3;

  // Bits of the status register
  localparam int ST_BUSY      = 0;
  localparam int ST_DONE      = 1;
  localparam int ST_FAIL      = 2;
  localparam int ST_ABORT     = 3;
  localparam int ST_READY_PIN = 4;
  localparam int ST_BYTE_LSB  = 8;

  // Flash status byte layout
  localparam int DATA_POLLING_BIT  = 7;
  localparam int TOGGLE_BIT_ONE    = 6;
  localparam int TIMEOUT_FLAG      = 5;
  localparam int ERASE_TIMER_BIT   = 3;
  localparam int TOGGLE_BIT_TWO    = 2;
  localparam int BUFFER_ABORT_FLAG = 1;

  localparam int CMD_LEN = 3;  // Writes in the abort clear sequence

  typedef enum logic [2:0] {
    S_IDLE    = 3'h0,
    S_RST_LOW = 3'h1,
    S_RST_REC = 3'h3,
    S_RD_ACC  = 3'h2,
    S_RD_GAP  = 3'h6,
    S_WR_LOW  = 3'h4,
    S_WR_HIGH = 3'h5
  } fws_state_type;

endpackage : fws_pkg

/* File: design/fws_sync.sv */
/*
  Three-stage pin synchroniser with agreement filter.
  Assumes asynchronous inputs; output follows once stages two and three
  agree on a bit.
*/
module fws_sync #(
  parameter int W = 1
) (
  input  logic         clk_sys,
  input  logic         rst_n,
  input  logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] ff1_reg;
  logic [W-1:0] ff2_reg;
  logic [W-1:0] ff3_reg;
  logic [W-1:0] dout_reg;
  logic [W-1:0] dout_next;

  // Take a bit only where the last two stages agree
  assign dout_next = (ff2_reg & ff3_reg) | (dout_reg & (ff2_reg ^ ff3_reg));
  assign dout      = dout_reg;

  // Shift chain
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ff1_reg  <= '0;
      ff2_reg  <= '0;
      ff3_reg  <= '0;
      dout_reg <= '0;
    end else begin
      ff1_reg  <= din;
      ff2_reg  <= ff1_reg;
      ff3_reg  <= ff2_reg;
      dout_reg <= dout_next;
    end
  end

endmodule : fws_sync

/* File: design/fws_flash_status_host.sv */
/*
  Host controller for a parallel flash: hardware reset sequencing,
  status polling by the toggle method, and the buffer abort clear
  command. Software reaches it through a simple register port.
  Assumes flash pins outside the clock domain; data bus is shared.
*/
// Decided for this implementation: strobed register access and the address map.
// Function
// - Host issues the buffer abort clear command after an abort.
// - Host never reads a program-suspended sector; other sectors give data. The host does not check this: it polls whatever address software sets.
// - Host polls status at a valid address of the operation.
// - Host polls at the last address loaded into the write buffer.
// - Host holds reset low at least 500 ns.
// - Host holds reset low at least 20 us to reach standby.
// - Host waits at least 50 ns after reset release before reading.
module fws_flash_status_host #(
  parameter int                ADDR_W   = 22,
  // Abort clear sequence: set to the part's command cycles
  parameter logic [3*ADDR_W-1:0] CLR_ADDRS = '0,
  parameter logic [23:0]       CLR_DATAS  = 24'h00_0000
) (
  input  logic                        clk_sys,
  input  logic                        rst_n,
  input  logic [fws_pkg::REG_AW-1:0]  reg_addr,
  input  logic [fws_pkg::REG_DW-1:0]  reg_wdata,
  input  logic                        reg_wr,
  input  logic                        reg_rd,
  output logic [fws_pkg::REG_DW-1:0]  reg_rdata,
  output logic [ADDR_W-1:0]           flash_addr,
  output logic                        flash_ce_n,
  output logic                        flash_oe_n,
  output logic                        flash_we_n,
  output logic                        flash_reset_n,
  input  logic [fws_pkg::DQ_W-1:0]    dq_in,
  output logic [fws_pkg::DQ_W-1:0]    dq_out,
  output logic                        dq_oe,
  input  logic                        ready_busy_n
);
  import fws_pkg::*;

  fws_state_type     state_reg, state_next;
  logic [CNT_W-1:0]  cnt_reg, cnt_next;
  logic [ADDR_W-1:0] poll_addr_reg, poll_addr_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic              ce_n_reg, ce_n_next;
  logic              oe_n_reg, oe_n_next;
  logic              we_n_reg, we_n_next;
  logic              rst_pin_reg, rst_pin_next;
  logic [DQ_W-1:0]   dq_out_reg, dq_out_next;
  logic              dq_oe_reg, dq_oe_next;
  logic [DQ_W-1:0]   byte_reg, byte_next;
  logic              prev_t1_reg, prev_t1_next;
  logic              first_reg, first_next;
  logic              tmo_seen_reg, tmo_seen_next;
  logic              done_reg, done_next;
  logic              fail_reg, fail_next;
  logic              abort_reg, abort_next;
  logic              algo_reg, algo_next;
  logic [1:0]        idx_reg, idx_next;
  logic [REG_DW-1:0] rdata_reg, rdata_next;
  logic [DQ_W-1:0]   dq_s;
  logic              rb_s;

  // Pin inputs cross into the clock domain
  fws_sync #(.W(DQ_W)) u_dq_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .din     (dq_in),
    .dout    (dq_s)
  );

  fws_sync #(.W(1)) u_rb_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .din     (ready_busy_n),
    .dout    (rb_s)
  );

  // Command and register decode
  logic wr_ctrl;
  logic wr_paddr;
  logic idle;
  logic cnt_done;
  logic toggled;
  logic [REG_DW-1:0] status_word;

  assign wr_ctrl  = reg_wr && (reg_addr == REG_CTRL);
  assign wr_paddr = reg_wr && (reg_addr == REG_POLL_ADDR);
  assign idle     = (state_reg == S_IDLE);
  assign cnt_done = (cnt_reg == '0);
  assign toggled  = dq_s[TOGGLE_BIT_ONE] != prev_t1_reg;

  // Status word of the controller
  assign status_word = {16'h0000, byte_reg, 3'b000, rb_s, abort_reg,
                        fail_reg, done_reg, ~idle};

  // Read data stand one cycle after the strobe
  assign rdata_next =
    !reg_rd                       ? '0 :
    (reg_addr == REG_POLL_ADDR)   ? REG_DW'(poll_addr_reg) :
    (reg_addr == REG_STATUS)      ? status_word : '0;

  assign poll_addr_next = (wr_paddr && idle) ? reg_wdata[ADDR_W-1:0]
                                             : poll_addr_reg;

  // Sequencer next state
  always_comb begin
    state_next    = state_reg;
    cnt_next      = cnt_done ? cnt_reg : cnt_reg - 1'b1;
    addr_next     = addr_reg;
    ce_n_next     = ce_n_reg;
    oe_n_next     = oe_n_reg;
    we_n_next     = we_n_reg;
    rst_pin_next  = rst_pin_reg;
    dq_out_next   = dq_out_reg;
    dq_oe_next    = dq_oe_reg;
    byte_next     = byte_reg;
    prev_t1_next  = prev_t1_reg;
    first_next    = first_reg;
    tmo_seen_next = tmo_seen_reg;
    done_next     = done_reg;
    fail_next     = fail_reg;
    abort_next    = abort_reg;
    algo_next     = algo_reg;
    idx_next      = idx_reg;
    unique case (state_reg)
      S_IDLE: begin
        if (wr_ctrl && (reg_wdata[CTRL_RESET] || reg_wdata[CTRL_STANDBY]))
        begin
          rst_pin_next = 1'b0;
          ce_n_next    = 1'b1;
          cnt_next     = reg_wdata[CTRL_STANDBY] ? RPD_CYC - 1'b1
                                                 : RP_CYC - 1'b1;
          algo_next    = ~rb_s;  // Algorithm running when busy is low
          done_next    = 1'b0;
          fail_next    = 1'b0;
          abort_next   = 1'b0;
          state_next   = S_RST_LOW;
        end else if (wr_ctrl && reg_wdata[CTRL_ABORT_CLEAR]) begin
          idx_next    = 2'd0;
          addr_next   = CLR_ADDRS[ADDR_W-1:0];
          dq_out_next = CLR_DATAS[DQ_W-1:0];
          dq_oe_next  = 1'b1;
          ce_n_next   = 1'b0;
          we_n_next   = 1'b0;
          cnt_next    = WP_CYC - 1'b1;
          state_next  = S_WR_LOW;
        end else if (wr_ctrl && reg_wdata[CTRL_POLL]) begin
          addr_next     = poll_addr_reg;
          ce_n_next     = 1'b0;
          oe_n_next     = 1'b0;
          cnt_next      = ACC_CYC - 1'b1;
          first_next    = 1'b1;
          tmo_seen_next = 1'b0;
          done_next     = 1'b0;
          fail_next     = 1'b0;
          abort_next    = 1'b0;
          state_next    = S_RD_ACC;
        end
      end
      S_RST_LOW: begin
        if (cnt_done) begin
          rst_pin_next = 1'b1;
          cnt_next   = algo_reg ? READY_CYC - 1'b1 : RH_CYC - 1'b1;
          state_next = S_RST_REC;
        end
      end
      S_RST_REC: begin
        if (cnt_done) begin
          done_next  = 1'b1;
          state_next = S_IDLE;
        end
      end
      S_RD_ACC: begin
        if (cnt_done) begin
          byte_next    = dq_s;  // status byte captured
          ce_n_next    = 1'b1;
          oe_n_next    = 1'b1;
          prev_t1_next = dq_s[TOGGLE_BIT_ONE];
          first_next   = 1'b0;
          cnt_next     = OEPH_CYC - 1'b1;
          state_next   = S_RD_GAP;
          if (!first_reg) begin
            if (!toggled) begin
              done_next  = 1'b0 | 1'b1;
              state_next = S_IDLE;
            end else if (dq_s[BUFFER_ABORT_FLAG]) begin
              abort_next = 1'b1;
              state_next = S_IDLE;
            end else if (tmo_seen_reg) begin
              fail_next  = 1'b1;
              state_next = S_IDLE;
            end else begin
              tmo_seen_next = dq_s[TIMEOUT_FLAG];
            end
          end
        end
      end
      S_RD_GAP: begin
        if (cnt_done) begin
          ce_n_next  = 1'b0;
          oe_n_next  = 1'b0;
          cnt_next   = ACC_CYC - 1'b1;
          state_next = S_RD_ACC;
        end
      end
      S_WR_LOW: begin
        if (cnt_done) begin
          we_n_next  = 1'b1;
          ce_n_next  = 1'b1;
          cnt_next   = WPH_CYC - 1'b1;
          state_next = S_WR_HIGH;
        end
      end
      S_WR_HIGH: begin
        if (cnt_done) begin
          if (idx_reg == 2'(CMD_LEN - 1)) begin
            dq_oe_next = 1'b0;
            abort_next = 1'b0;
            done_next  = 1'b1;
            state_next = S_IDLE;
          end else begin
            idx_next    = idx_reg + 1'b1;
            addr_next   = CLR_ADDRS[(idx_reg + 1'b1)*ADDR_W +: ADDR_W];
            dq_out_next = CLR_DATAS[(idx_reg + 1'b1)*DQ_W +: DQ_W];
            ce_n_next   = 1'b0;
            we_n_next   = 1'b0;
            cnt_next    = WP_CYC - 1'b1;
            state_next  = S_WR_LOW;
          end
        end
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  // Pins and state registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= S_IDLE;
      cnt_reg      <= '0;
      poll_addr_reg <= '0;
      addr_reg     <= '0;
      ce_n_reg     <= 1'b1;
      oe_n_reg     <= 1'b1;
      we_n_reg     <= 1'b1;
      rst_pin_reg  <= 1'b1;
      dq_out_reg   <= '0;
      dq_oe_reg    <= 1'b0;
      byte_reg     <= '0;
      prev_t1_reg  <= 1'b0;
      first_reg    <= 1'b0;
      tmo_seen_reg <= 1'b0;
      done_reg     <= 1'b0;
      fail_reg     <= 1'b0;
      abort_reg    <= 1'b0;
      algo_reg     <= 1'b0;
      idx_reg      <= 2'd0;
      rdata_reg    <= '0;
    end else begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      poll_addr_reg <= poll_addr_next;
      addr_reg     <= addr_next;
      ce_n_reg     <= ce_n_next;
      oe_n_reg     <= oe_n_next;
      we_n_reg     <= we_n_next;
      rst_pin_reg  <= rst_pin_next;
      dq_out_reg   <= dq_out_next;
      dq_oe_reg    <= dq_oe_next;
      byte_reg     <= byte_next;
      prev_t1_reg  <= prev_t1_next;
      first_reg    <= first_next;
      tmo_seen_reg <= tmo_seen_next;
      done_reg     <= done_next;
      fail_reg     <= fail_next;
      abort_reg    <= abort_next;
      algo_reg     <= algo_next;
      idx_reg      <= idx_next;
      rdata_reg    <= rdata_next;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata     = rdata_reg;
  assign flash_addr    = addr_reg;
  assign flash_ce_n    = ce_n_reg;
  assign flash_oe_n    = oe_n_reg;
  assign flash_we_n    = we_n_reg;
  assign flash_reset_n = rst_pin_reg;
  assign dq_out        = dq_out_reg;
  assign dq_oe         = dq_oe_reg;

endmodule : fws_flash_status_host

/* File: dv/fws_flash_status_host_asserts.sv */
/*
  Pin timing checker for the flash status host.
  Assumes it is bound to the host top module and sees only its ports.
*/
module fws_flash_status_host_asserts
  import fws_pkg::*;
#(
  parameter int ADDR_W = 22
) (
  input logic                clk_sys,
  input logic                rst_n,
  input logic [REG_AW-1:0]   reg_addr,
  input logic [REG_DW-1:0]   reg_wdata,
  input logic                reg_wr,
  input logic [ADDR_W-1:0]   flash_addr,
  input logic                flash_ce_n,
  input logic                flash_oe_n,
  input logic                flash_we_n,
  input logic                flash_reset_n,
  input logic                dq_oe
);
  logic [15:0] low_cnt_reg;
  logic        standby_reg;
  wire         ctrl_wr = reg_wr && (reg_addr == REG_CTRL);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Length of the current flash reset pulse, and whether it is a standby
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt_reg <= 16'h0000;
      standby_reg <= 1'b0;
    end else begin
      low_cnt_reg <= flash_reset_n ? 16'h0000 : low_cnt_reg + 16'h0001;
      if (ctrl_wr && reg_wdata[CTRL_STANDBY] && flash_reset_n)
        standby_reg <= 1'b1;
      else if (flash_reset_n && (low_cnt_reg != 16'h0000))
        standby_reg <= 1'b0;
    end
  end

  property p_rst_pulse;
    $rose(flash_reset_n) |-> low_cnt_reg >= RP_CYC;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse)
    else $error("reset pulse too short");
  property p_rst_standby;
    $rose(flash_reset_n) && standby_reg |-> low_cnt_reg >= RPD_CYC;
  endproperty
  a_rst_standby: assert property (p_rst_standby)
    else $error("standby reset too short");
  property p_read_after_rst;
    $rose(flash_reset_n) |-> flash_oe_n [*5];
  endproperty
  a_read_after_rst: assert property (p_read_after_rst)
    else $error("read too soon after reset");
  property p_addr_hold;
    !flash_oe_n && !$past(flash_oe_n) |-> $stable(flash_addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address moved during read");
  property p_read_len;
    $fell(flash_oe_n) |-> (!flash_oe_n && !flash_ce_n) [*8]
      ##1 (!flash_oe_n) [*6] ##1 flash_oe_n;
  endproperty
  a_read_len: assert property (p_read_len)
    else $error("status read length wrong");
  property p_read_gap;
    $rose(flash_oe_n) |-> flash_oe_n [*2];
  endproperty
  a_read_gap: assert property (p_read_gap)
    else $error("gap between reads too short");
  property p_wr_pulse;
    $fell(flash_we_n) |-> (!flash_we_n && !flash_ce_n && dq_oe) [*4]
      ##1 (flash_we_n [*3]);
  endproperty
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("command write pulse wrong");
  property p_no_contend;
    !flash_oe_n |-> !dq_oe && flash_we_n;
  endproperty
  a_no_contend: assert property (p_no_contend)
    else $error("host drives data during read");
endmodule : fws_flash_status_host_asserts

bind fws_flash_status_host fws_flash_status_host_asserts #(
  .ADDR_W(ADDR_W)
) i_fws_flash_status_host_asserts (
  .clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .flash_addr,
  .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_reset_n, .dq_oe
);

/* File: dv/fws_flash_model.sv */
/*
  Behavioural flash: status byte, toggle, abort and timeout flags,
  ready/busy pin. Assumes the bench sets the operation in its variables.
*/
module fws_flash_model
  import fws_pkg::*;
#(
  parameter logic [7:0] ARRAY_BYTE = 8'h5a,
  parameter logic [7:0] PROG_BYTE  = 8'ha5
) (
  input  logic [21:0]     flash_addr,
  input  logic            flash_oe_n,
  input  logic            flash_we_n,
  input  logic            flash_reset_n,
  input  logic [DQ_W-1:0] dq_out,
  output logic [DQ_W-1:0] dq_in,
  output logic            ready_busy_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int          busy_reads = 0;    // Status reads before completion
  logic        abort_f    = 1'b0;
  logic        timeout_f  = 1'b0;
  int          acc_ns     = 20;
  int          wr_count   = 0;
  logic [21:0] last_addr  = '0;
  logic        tog        = 1'b0;
  logic [7:0]  last_q     = 8'h00;
  int          mode       = 0;    // 0 program, 1 erase, 2 erase suspend
  logic        tog2       = 1'b0;
  logic [65:0] wr_addrs   = '0;   // Command writes, first one lowest
  logic [23:0] wr_datas   = '0;
  wire         active     = (busy_reads > 0) || abort_f || timeout_f;
  wire         susp       = (mode == 2);

  assign ready_busy_n = active ? 1'b0 : 1'b1;
  initial dq_in = 8'h00;

  always @(negedge flash_oe_n) begin
    dq_in = ~last_q;
    // sleep on a stable address only saves power here
    last_addr = flash_addr;
    #(acc_ns);
    // erase busy: bit 7 zero, timer one, both toggles
    // suspended sector: bit 7 one, bit 6 static, bit 2 toggles
    dq_in = susp ? {1'b1, tog, 3'b000, tog2, 2'b00} :
            !active ? ARRAY_BYTE :
            (mode == 1) ? {1'b0, tog, timeout_f, 1'b0, 1'b1, tog2, 2'b00} :
            {~PROG_BYTE[7], tog, timeout_f, 3'b000, abort_f, 1'b0};
    last_q = dq_in;
  end

  // toggle per read; released bus shows the inverse
  always @(posedge flash_oe_n) begin
    dq_in = ~last_q;
    if (active) tog = ~tog;
    if (active || susp) tog2 = ~tog2;
    if (busy_reads > 0) busy_reads--;
  end

  // abort cleared by the command writes
  always @(posedge flash_we_n) begin
    wr_count++;
    wr_addrs = {flash_addr, wr_addrs[65:22]};
    wr_datas = {dq_out, wr_datas[23:8]};
    if (wr_count == CMD_LEN) abort_f = 1'b0;
  end

  always @(negedge flash_reset_n) begin
    busy_reads = 0;
    mode = 0;
    abort_f = 1'b0;
    timeout_f = 1'b0;
  end
endmodule : fws_flash_model

/* File: dv/test_fws_flash_status_host.sv */
/*
  Self-checking bench for the flash status host with a behavioural flash.
  Assumes a 100 MHz clock and the register map of the package.
*/
module test_fws_flash_status_host
  import fws_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk_sys = 1'b0;
  logic              rst_n = 1'b0;
  logic [REG_AW-1:0] reg_addr = '0;
  logic [REG_DW-1:0] reg_wdata = '0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [REG_DW-1:0] reg_rdata;
  logic [21:0]       flash_addr;
  logic              flash_ce_n, flash_oe_n, flash_we_n, flash_reset_n;
  logic [DQ_W-1:0]   dq_in, dq_out;
  logic              dq_oe, ready_busy_n;
  int                fail_count = 0;
  int                total_checks = 0;
  int                rst_low = 0;
  logic [15:0]       seed = 16'h2b11;  // Seed 11025

  // Arbitrary clear sequence, so the command writes can be told apart
  localparam logic [65:0] CLR_A = {22'h2e37, 22'h15c4, 22'h0a1c};
  localparam logic [23:0] CLR_D = 24'h3c_96e1;

  fws_flash_status_host #(
    .CLR_ADDRS (CLR_A),
    .CLR_DATAS (CLR_D)
  ) i_fws_flash_status_host (
    .clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .flash_addr, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_reset_n,
    .dq_in, .dq_out, .dq_oe, .ready_busy_n
  );
  fws_flash_model i_fws_flash_model (
    .flash_addr, .flash_oe_n, .flash_we_n, .flash_reset_n, .dq_out, .dq_in,
    .ready_busy_n
  );

  // Clock and flash reset pulse length monitor
  initial forever #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (!flash_reset_n) rst_low++;

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  // Status expected after a poll: idle, program, abort, timeout, erase,
  // erase-suspended sector
  function automatic logic [31:0] exp_status(input int m);
    logic [7:0] b;
    logic [4:0] f;
    b = (m == 2) ? 8'h02 : (m == 3) ? 8'h20 : (m == 5) ? 8'h80 : 8'h5a;
    f = (m == 2) ? 5'h08 : (m == 3) ? 5'h04 : 5'h12;
    return {16'h0000, b & 8'hbf, 3'b000, f};
  endfunction : exp_status

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read

  task automatic wait_idle(output logic [31:0] st);
    st = 32'h0000_0001;
    for (int i = 0; i < 3000 && st[ST_BUSY] !== 1'b0; i++)
      reg_read(REG_STATUS, st);
  endtask : wait_idle

  task automatic end_of_test();
    if (fail_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  // Watchdog well beyond the expected run length
  initial begin
    #400000;
    fail_count++;
    end_of_test();
  end

  initial begin
    logic [31:0] st;
    logic [21:0] pa;
    logic [31:0] msk;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    // Ready pin needs the synchroniser's latency before it reads high
    repeat (4) @(posedge clk_sys);
    reg_read(REG_STATUS, st);
    check(st, 32'h0000_0010);
    reg_read(REG_CTRL, st);
    check(st, 32'h0000_0000);
    reg_read(4'hf, st);
    check(st, 32'h0000_0000);
    // Poll each kind of operation at a random address
    for (int m = 0; m < 6; m++) begin
      seed = lfsr(seed);
      pa = {seed[5:0], seed};
      reg_write(REG_POLL_ADDR, {10'h000, pa});
      i_fws_flash_model.busy_reads = (m == 1 || m == 4) ? 2 + seed[2:0] : 0;
      i_fws_flash_model.mode = (m == 4) ? 1 : (m == 5) ? 2 : 0;
      i_fws_flash_model.abort_f = (m == 2);
      i_fws_flash_model.timeout_f = (m == 3);
      i_fws_flash_model.acc_ns = seed[0] ? 20 : 90;
      reg_write(REG_CTRL, 32'h0000_0001);
      reg_write(REG_POLL_ADDR, 32'h0000_0000);
      reg_read(REG_POLL_ADDR, st);
      check(st, {10'h000, pa});
      wait_idle(st);
      msk = (m == 5) ? 32'h0000_bb1f : 32'h0000_bf1f;
      check(st & msk, exp_status(m));
      check({10'h000, i_fws_flash_model.last_addr}, {10'h000, pa});
      if (m == 2) begin
        i_fws_flash_model.wr_count = 0;
        reg_write(REG_CTRL, 32'h0000_0008);
        wait_idle(st);
        reg_read(REG_STATUS, st);
        check(st & 32'h0000_001f, 32'h0000_0012);
        check(i_fws_flash_model.wr_count, CMD_LEN);
        check(32'(i_fws_flash_model.wr_datas), 32'(CLR_D));
        for (int i = 0; i < 3; i++)
          check(32'(i_fws_flash_model.wr_addrs[i*22 +: 22]),
                32'(CLR_A[i*22 +: 22]));
      end
    end
    // Hardware reset during a timed-out operation, then standby reset
    i_fws_flash_model.mode = 0;
    i_fws_flash_model.timeout_f = 1'b1;
    repeat (4) @(posedge clk_sys);
    for (int k = 1; k < 3; k++) begin
      rst_low = 0;
      reg_write(REG_CTRL, 32'h0000_0001 << k);
      wait_idle(st);
      check(st & 32'h0000_001f, 32'h0000_0012);
      check(rst_low, (k == 1) ? RP_CYC : RPD_CYC);
    end
    end_of_test();
  end
endmodule : test_fws_flash_status_host
